//--- verilog/fsr_pkg.sv
// Constants, register map and field layout of the fiber control/status bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
//
// What this block does
// - Loopback enable turns serial input back out
// - Loopback kind picks the loopback path
// - Kind zero via PCS, one raw codes
// - Power policy resets one; zero allows powerdown
// - Written power policy applies at software reset
// - Media mode field mirrors low two mode bits
// - Mirror codes: 3,2,1,0 per media mode
// - Speed and duplex valid once resolved set
// - Resolved set at negotiation done or disabled
// - Speed codes 2,1,0; fiber 100 forces 1
// - Duplex one full; fiber 100 follows control
// - Page received latches high; fiber 100 zero
package fsr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL     = 8'h10; // Fiber control one
   localparam logic [7:0] IDX_STAT     = 8'h11; // Fiber status
   localparam logic [7:0] IDX_IRQ_STAT = 8'h1C; // Sticky event bits
   localparam logic [7:0] IDX_IRQ_MASK = 8'h1D; // Event mask
   localparam logic [7:0] IDX_SOFT_RST = 8'h1E; // Software reset strobe

   // Control register field positions
   localparam int CTL_LB_EN   = 12; // Loopback enable
   localparam int CTL_RSV9    = 9;  // Reserved read/write, retained
   localparam int CTL_LB_KIND = 8;  // Loopback kind
   localparam int CTL_RSV5    = 5;  // Reserved pair, top bit
   localparam int CTL_RSV4    = 4;  // Reserved pair, low bit
   localparam int CTL_PWR     = 3;  // Host side powerdown policy
   localparam int CTL_RSV2    = 2;  // Reserved, must stay one
   localparam int CTL_MODE_HI = 1;  // Media mode mirror, top bit

   // Status register field positions
   localparam int ST_SPEED_HI = 15; // Speed, top bit
   localparam int ST_DUPLEX   = 13; // Duplex
   localparam int ST_PAGE     = 12; // Page received, latched
   localparam int ST_RESOLVED = 11; // Speed and duplex resolved

   // Interrupt event bit positions
   localparam int EV_PAGE     = 0;  // Page received
   localparam int EV_RESOLVED = 1;  // Resolved went high
   localparam int EV_W        = 2;  // Number of events

   // Reset values
   localparam logic       RST_LB_EN   = 1'h0;
   localparam logic       RST_LB_KIND = 1'h0;
   localparam logic       RST_PWR     = 1'h1;
   localparam logic       RST_RSV2    = 1'h1;
   localparam logic [1:0] RST_RSV54   = 2'h0;
   localparam logic       RST_RSV9    = 1'h0;

   // Media mode mirror codes
   localparam logic [1:0] MM_FX100      = 2'h0;
   localparam logic [1:0] MM_BASEX      = 2'h1;
   localparam logic [1:0] MM_SGMII_SYS  = 2'h2;
   localparam logic [1:0] MM_SGMII_MED  = 2'h3;

   // Speed codes
   localparam logic [1:0] SPD_10   = 2'h0;
   localparam logic [1:0] SPD_100  = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;

   // Writable control fields travel together
   typedef struct packed {
      logic       lb_en;   // Loopback enable
      logic       lb_kind; // Loopback kind
      logic       rsv9;    // Reserved bit nine
      logic [1:0] rsv54;   // Reserved bits five and four
      logic       pwr_wr;  // Power policy as written
      logic       rsv2;    // Reserved bit two
   } fsr_ctrl_t;

   // Link status coming from the PCS and negotiation logic
   typedef struct packed {
      logic       an_enable; // Negotiation enabled
      logic       an_done;   // Negotiation complete
      logic [1:0] speed;     // Negotiated speed code
      logic       duplex;    // Negotiated duplex
      logic       page_rx;   // One-cycle page arrival pulse
   } fsr_link_t;

endpackage

//--- verilog/fsr_regs.sv
// Fiber control/status register bank with serial loopback steering.
// Assumes all inputs are synchronous to clk_i; Avalon-MM byte addressing.
`timescale 1ns/1ns
`default_nettype none

module fsr_regs
   import fsr_pkg::*;
#(
   parameter int ADDR_W = 8 // Byte address width
) (
   input  wire logic           clk_i,             // 250 MHz clock
   input  wire logic           rstn_i,            // Async reset, active low
   input  wire logic [ADDR_W-1:0] avs_address,    // Byte address
   input  wire logic           avs_read,          // Read request
   input  wire logic           avs_write,         // Write request
   input  wire logic [31:0]    avs_writedata,     // Write data
   input  wire logic [3:0]     avs_byteenable,    // Byte lanes
   output logic [31:0]         avs_readdata,      // Read data
   output logic                avs_waitrequest,   // Stall
   input  wire logic [2:0]     mode_sel_i,        // Programmed mode field
   input  wire fsr_link_t      link_i,            // Link status
   input  wire logic           duplex_ctrl_i,     // Fiber duplex control
   input  wire logic           dev_powerdown_i,   // Device powerdown
   input  wire logic           energy_detect_i,   // Energy detect state
   input  wire logic [9:0]     serial_rx_i,       // Raw received codes
   input  wire logic [9:0]     pcs_tx_i,          // Normal transmit codes
   input  wire logic [9:0]     pcs_loop_i,        // PCS looped codes
   output logic [9:0]          serial_tx_o,       // Codes to serializer
   output logic                pcs_loop_sel_o,    // PCS loop path active
   output logic                host_if_pwrdn_o,   // Host side powered down
   output logic                irq_o              // Level interrupt
);

   // Elaboration check on the address width
   if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
      $error("fsr_regs: ADDR_W must be 8 to 16");
   end
   // All assertions below run on this clock and reset
   default clocking fsr_cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   ////////////////////////////////////////////////////////////////////////
   // Bus decode and waitrequest
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      FSR_IDLE = 2'b01, // No access under way
      FSR_ACK  = 2'b10  // Answer cycle
   } fsr_bus_t;

   fsr_bus_t    bus_ff;       // Bus answer state
   fsr_bus_t    nxt_bus;      // Next bus state
   fsr_ctrl_t   ctrl_ff;      // Writable control fields
   logic        pwr_eff_ff;   // Power policy in force
   logic [1:0]  speed_ff;     // Captured speed
   logic        duplex_ff;    // Captured duplex
   logic        page_ff;      // Latched page received
   logic        res_ff;       // Previous resolved
   logic [EV_W-1:0] ev_sts_ff; // Sticky events
   logic [EV_W-1:0] ev_msk_ff; // Event mask
   logic        soft_rst_ff;  // Software reset pulse
   logic [31:0] rdata_ff;     // Read data
   logic [9:0]  tx_ff;        // Serializer data
   logic        lb_sel_ff;    // PCS loop select

   logic [7:0]  idx;          // Register index
   logic        addr_ok;      // Word aligned and in range
   logic        done;         // Access completes this edge
   logic        wr_go;        // Write takes effect
   logic        rd_go;        // Read takes effect
   logic        is_fx;        // Fiber 100 mode
   logic        resolved;     // Speed and duplex resolved
   logic [1:0]  mm_code;      // Media mode mirror
   logic [1:0]  spd_view;     // Speed as reported
   logic        dup_view;     // Duplex as reported
   logic [EV_W-1:0] ev_set;   // Events this cycle
   logic [15:0] ctl_word;     // Control register image
   logic [15:0] st_word;      // Status register image

   // Index from byte address; upper bits must be zero
   assign idx     = 8'(32'(avs_address) >> 2);
   assign addr_ok = (avs_address[1:0] == 2'h0) &&
                    ((32'(avs_address) >> 10) == 32'h0);
   assign done    = (bus_ff == FSR_ACK);
   assign wr_go   = done & avs_write & addr_ok;
   assign rd_go   = done & avs_read & addr_ok;
   assign avs_waitrequest = (avs_read | avs_write) & ~done;
   assign avs_readdata    = rdata_ff;

   // One wait cycle, then answer
   always_comb begin
      nxt_bus = FSR_IDLE;
      case (bus_ff)
         FSR_IDLE: nxt_bus = (avs_read | avs_write) ? FSR_ACK : FSR_IDLE;
         FSR_ACK:  nxt_bus = FSR_IDLE;
         default:  nxt_bus = FSR_IDLE;
      endcase
   end

   // Bus state register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_ff <= FSR_IDLE;
      end else begin
         bus_ff <= nxt_bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode mirror and status views
   ////////////////////////////////////////////////////////////////////////
   // Mirror low bits of the mode field
   assign mm_code = mode_sel_i[1:0];
   assign is_fx   = (mm_code == MM_FX100);

   // Resolved when done, negotiation off, or fiber 100
   assign resolved = is_fx | ~link_i.an_enable | link_i.an_done;

   // Fiber 100 forces speed; duplex follows control bit
   assign spd_view = is_fx ? SPD_100 : speed_ff;
   assign dup_view = is_fx ? duplex_ctrl_i : duplex_ff;

   // Register images
   always_comb begin
      ctl_word = 16'h0000;
      ctl_word[CTL_LB_EN]   = ctrl_ff.lb_en;
      ctl_word[CTL_RSV9]    = ctrl_ff.rsv9;
      ctl_word[CTL_LB_KIND] = ctrl_ff.lb_kind;
      ctl_word[CTL_RSV5]    = ctrl_ff.rsv54[1];
      ctl_word[CTL_RSV4]    = ctrl_ff.rsv54[0];
      ctl_word[CTL_PWR]     = ctrl_ff.pwr_wr;
      ctl_word[CTL_RSV2]    = ctrl_ff.rsv2;
      ctl_word[CTL_MODE_HI -: 2] = mm_code;
      st_word = 16'h0000;
      st_word[ST_SPEED_HI -: 2] = spd_view;
      st_word[ST_DUPLEX]   = dup_view;
      st_word[ST_PAGE]     = page_ff & ~is_fx;
      st_word[ST_RESOLVED] = resolved;
   end

   // Read data prepared during the wait cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && !done) begin
         if (!addr_ok) begin
            rdata_ff <= 32'h0000_0000;
         end else begin
            case (idx)
               IDX_CTRL:     rdata_ff <= {16'h0000, ctl_word};
               IDX_STAT:     rdata_ff <= {16'h0000, st_word};
               IDX_IRQ_STAT: rdata_ff <= {30'h0, ev_sts_ff};
               IDX_IRQ_MASK: rdata_ff <= {30'h0, ev_msk_ff};
               default:      rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and software reset
   ////////////////////////////////////////////////////////////////////////
   // Software reset strobe, self clearing
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= wr_go && idx == IDX_SOFT_RST &&
                        avs_byteenable[0] && avs_writedata[0];
      end
   end

   // Writable control fields; loopback enable clears on soft reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_ff.lb_en   <= RST_LB_EN;
         ctrl_ff.lb_kind <= RST_LB_KIND;
         ctrl_ff.rsv9    <= RST_RSV9;
         ctrl_ff.rsv54   <= RST_RSV54;
         ctrl_ff.pwr_wr  <= RST_PWR;
         ctrl_ff.rsv2    <= RST_RSV2;
      end else if (soft_rst_ff) begin
         ctrl_ff.lb_en <= RST_LB_EN;
      end else if (wr_go && idx == IDX_CTRL) begin
         if (avs_byteenable[0]) begin
            ctrl_ff.rsv54  <= avs_writedata[CTL_RSV5:CTL_RSV4];
            ctrl_ff.pwr_wr <= avs_writedata[CTL_PWR];
            ctrl_ff.rsv2   <= avs_writedata[CTL_RSV2];
         end
         if (avs_byteenable[1]) begin
            ctrl_ff.lb_en   <= avs_writedata[CTL_LB_EN];
            ctrl_ff.lb_kind <= avs_writedata[CTL_LB_KIND];
            ctrl_ff.rsv9    <= avs_writedata[CTL_RSV9];
         end
      end
   end

   // Power policy takes the written value only at soft reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pwr_eff_ff <= RST_PWR;
      end else if (soft_rst_ff) begin
         pwr_eff_ff <= ctrl_ff.pwr_wr;
      end
   end

   // Host side may power down only when policy allows
   assign host_if_pwrdn_o = ~pwr_eff_ff &
                            (dev_powerdown_i | energy_detect_i);

   ////////////////////////////////////////////////////////////////////////
   // Loopback data path
   ////////////////////////////////////////////////////////////////////////
   // Pick serializer source: normal, PCS loop, or raw codes
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_ff     <= 10'h000;
         lb_sel_ff <= 1'b0;
      end else begin
         lb_sel_ff <= ctrl_ff.lb_en & ~ctrl_ff.lb_kind;
         if (!ctrl_ff.lb_en) begin
            tx_ff <= pcs_tx_i;
         end else if (ctrl_ff.lb_kind) begin
            tx_ff <= serial_rx_i;
         end else begin
            tx_ff <= pcs_loop_i;
         end
      end
   end

   assign serial_tx_o    = tx_ff;
   assign pcs_loop_sel_o = lb_sel_ff;

   ////////////////////////////////////////////////////////////////////////
   // Status capture
   ////////////////////////////////////////////////////////////////////////
   // Speed and duplex kept across soft reset; updated while resolved
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         speed_ff  <= SPD_10;
         duplex_ff <= 1'b0;
      end else if (resolved) begin
         speed_ff  <= link_i.speed;
         duplex_ff <= link_i.duplex;
      end
   end

   // Latched page flag; new page wins over the read clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         page_ff <= 1'b0;
      end else if (link_i.page_rx && !is_fx) begin
         page_ff <= 1'b1;
      end else if (soft_rst_ff || is_fx) begin
         page_ff <= 1'b0;
      end else if (rd_go && idx == IDX_STAT) begin
         page_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts
   ////////////////////////////////////////////////////////////////////////
   // Event sources
   always_comb begin
      ev_set = '0;
      ev_set[EV_PAGE]     = link_i.page_rx & ~is_fx;
      ev_set[EV_RESOLVED] = resolved & ~res_ff;
   end

   // Sticky status, write one clears, set wins
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ev_sts_ff <= '0;
         res_ff    <= 1'b0;
      end else begin
         res_ff <= resolved;
         if (wr_go && idx == IDX_IRQ_STAT && avs_byteenable[0]) begin
            ev_sts_ff <= (ev_sts_ff & ~avs_writedata[EV_W-1:0]) | ev_set;
         end else begin
            ev_sts_ff <= ev_sts_ff | ev_set;
         end
      end
   end

   // Mask register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ev_msk_ff <= '0;
      end else if (wr_go && idx == IDX_IRQ_MASK && avs_byteenable[0]) begin
         ev_msk_ff <= avs_writedata[EV_W-1:0];
      end
   end

   assign irq_o = |(ev_sts_ff & ev_msk_ff);

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////
   a_loop_raw: assert property (
      (ctrl_ff.lb_en && ctrl_ff.lb_kind) |=> tx_ff == $past(serial_rx_i))
      else $error("raw loopback data mismatch");
   a_loop_norm: assert property (
      !ctrl_ff.lb_en |=> serial_tx_o == $past(pcs_tx_i))
      else $error("normal path data mismatch");
   a_loop_pcs: assert property (
      (ctrl_ff.lb_en && !ctrl_ff.lb_kind)
      |=> pcs_loop_sel_o && tx_ff == $past(pcs_loop_i))
      else $error("PCS loopback path mismatch");
   a_pwr_hold: assert property (
      !soft_rst_ff |=> $stable(pwr_eff_ff))
      else $error("power policy changed without soft reset");
   a_pwr_gate: assert property (
      pwr_eff_ff |-> !host_if_pwrdn_o)
      else $error("host side powered down while policy forbids");
   a_fx_speed: assert property (
      (is_fx && avs_read && !done && addr_ok && idx == IDX_STAT)
      |=> avs_readdata[ST_SPEED_HI -: 2] == SPD_100)
      else $error("fiber 100 speed code wrong");
   a_fx_page: assert property (
      is_fx |=> !page_ff)
      else $error("page flag set in fiber 100 mode");
   a_page_set: assert property (
      (link_i.page_rx && !is_fx) |=> page_ff)
      else $error("page flag not latched");
   a_page_clr: assert property (
      (rd_go && idx == IDX_STAT && !link_i.page_rx) |=> !page_ff)
      else $error("page flag not cleared by read");
   a_res_andis: assert property (
      !link_i.an_enable |-> st_word[ST_RESOLVED])
      else $error("resolved low with negotiation off");
   a_bus_wait: assert property (
      ($rose(avs_read) && !done) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   c_raw_loop: cover property (ctrl_ff.lb_en && ctrl_ff.lb_kind);
   c_pwr_upd: cover property (soft_rst_ff && !ctrl_ff.pwr_wr);
   c_page_rd: cover property (page_ff && rd_go && idx == IDX_STAT);
   c_irq: cover property ($rose(irq_o));

endmodule // fsr_regs

`default_nettype wire

//--- dv/test_fsr_regs.sv
// Self-checking bench for the fiber control/status register bank.
// Assumes fsr_pkg is compiled first; drives all ports from the bench.
`timescale 1ns/1ns
`default_nettype none

module test_fsr_regs
   import fsr_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic        clk_i;           // 250 MHz clock
   logic        rstn_i;          // Async reset, active low
   logic [9:0]  avs_address;     // Byte address
   logic        avs_read;        // Read request
   logic        avs_write;       // Write request
   logic [31:0] avs_writedata;   // Write data
   logic [3:0]  avs_byteenable;  // Byte lanes
   logic [31:0] avs_readdata;    // Read data
   logic        avs_waitrequest; // Stall
   logic [2:0]  mode_sel;        // Programmed mode field
   fsr_link_t   link;            // Link status
   logic        dup_ctrl;        // Fiber duplex control
   logic        dev_pd;          // Device powerdown
   logic        energy;          // Energy detect state
   logic [9:0]  serial_tx;       // Codes to serializer
   logic        loop_sel;        // PCS loop path active
   logic        host_pd;         // Host side powered down
   logic        irq;             // Level interrupt
   int          fail_count;      // Mismatches
   int          num_checks;      // Comparisons made
   logic [31:0] q;               // Scratch read data

   // Byte addresses of the registers
   localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'h0};
   localparam logic [9:0] A_STAT = {IDX_STAT, 2'h0};
   localparam logic [9:0] A_IST  = {IDX_IRQ_STAT, 2'h0};
   localparam logic [9:0] A_IMSK = {IDX_IRQ_MASK, 2'h0};
   localparam logic [9:0] A_SRST = {IDX_SOFT_RST, 2'h0};

   // Loopback table: control value and expected source
   logic [31:0] cv [3] = '{32'h0000_0004, 32'h0000_1104, 32'h0000_1004};
   logic [9:0]  ex [3] = '{10'h155, 10'h2AA, 10'h3C3};

   fsr_regs #(.ADDR_W(10)) i_dut (
      .clk_i           (clk_i),
      .rstn_i          (rstn_i),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .mode_sel_i      (mode_sel),
      .link_i          (link),
      .duplex_ctrl_i   (dup_ctrl),
      .dev_powerdown_i (dev_pd),
      .energy_detect_i (energy),
      .serial_rx_i     (10'h2AA),
      .pcs_tx_i        (10'h155),
      .pcs_loop_i      (10'h3C3),
      .serial_tx_o     (serial_tx),
      .pcs_loop_sel_o  (loop_sel),
      .host_if_pwrdn_o (host_pd),
      .irq_o           (irq)
   );

   // Free-running clock
   always #2 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM master; holds request until waitrequest is low
   task automatic xfer(input logic wr, input logic [9:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Waitrequest and read data are sampled at the rising edge
      @(posedge clk_i);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Let the answer edge settle before the caller looks
      @(posedge clk_i);
      if (n >= 50) begin
         fail_count++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, q);
   endtask

   // Read and compare the bits under the mask
   task automatic rd(input logic [9:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      xfer(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask

   // One-cycle page arrival pulse
   task automatic page();
      @(posedge clk_i);
      link.page_rx <= 1'b1;
      @(posedge clk_i);
      link.page_rx <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk_i = 0; rstn_i = 0; avs_address = '0; avs_read = 0; avs_write = 0;
      avs_writedata = '0; avs_byteenable = 4'hF; mode_sel = 3'h5;
      link = '0; link.an_enable = 1'b1; link.speed = 2'h2;
      link.duplex = 1'b1; dup_ctrl = 0; dev_pd = 0; energy = 0;
      fail_count = 0; num_checks = 0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      // Reset values and mirror of mode bits
      rd(A_CTRL, 32'h0000_000D, 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++) begin
         mode_sel <= {1'b1, 2'(i)};
         rd(A_CTRL, 32'(i), 32'h3);
      end
      // Each loopback path in turn
      for (int k = 0; k < 3; k++) begin
         wr(A_CTRL, cv[k]);
         repeat (3) @(posedge clk_i);
         chk({22'h0, serial_tx}, {22'h0, ex[k]});
         chk({31'h0, loop_sel}, {31'h0, k == 2});
      end
      // Power policy waits for software reset
      dev_pd <= 1'b1;
      wr(A_CTRL, 32'h0000_1104);
      repeat (2) @(posedge clk_i);
      chk({31'h0, host_pd}, 32'h0);
      rd(A_CTRL, 32'h0000_1104, 32'h0000_133C);
      wr(A_SRST, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, host_pd}, 32'h1);
      rd(A_CTRL, 32'h0000_0104, 32'h0000_133C);
      dev_pd <= 1'b0;
      energy <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({31'h0, host_pd}, 32'h1);
      energy <= 1'b0;
      // Resolution by negotiation, then with it disabled
      mode_sel <= 3'h1;
      wr(A_IST, 32'h3);
      rd(A_STAT, 32'h0, 32'h0000_0800);
      wr(A_IMSK, 32'h2);
      link.an_done <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      rd(A_STAT, 32'h0000_A800, 32'h0000_E800);
      wr(A_IST, 32'h2);
      chk({31'h0, irq}, 32'h0);
      link.an_done <= 1'b0;
      link.an_enable <= 1'b0;
      for (int s = 0; s < 3; s++) begin
         link.speed <= 2'(s);
         link.duplex <= s[0];
         rd(A_STAT, {16'h0, 2'(s), s[0], 2'h1, 11'h0}, 32'hE800);
      end
      // Latched page flag and its interrupt
      wr(A_IMSK, 32'h1);
      page();
      chk({31'h0, irq}, 32'h1);
      rd(A_STAT, 32'h0000_1000, 32'h0000_1000);
      rd(A_STAT, 32'h0, 32'h0000_1000);
      rd(A_IST, 32'h1, 32'h1);
      wr(A_IST, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(A_IMSK, 32'h0);
      page();
      chk({31'h0, irq}, 32'h0);
      rd(A_IST, 32'h1, 32'h1);
      // Fiber 100 overrides speed, duplex and page flag
      mode_sel <= 3'h0;
      link.an_enable <= 1'b1;
      link.speed <= 2'h2;
      link.duplex <= 1'b0;
      dup_ctrl <= 1'b1;
      page();
      rd(A_STAT, 32'h0000_6800, 32'h0000_F800);
      dup_ctrl <= 1'b0;
      rd(A_STAT, 32'h0000_4800, 32'h0000_E800);
      // Unmapped place and strobe register read zero
      rd(10'h07C, 32'h0, 32'hFFFF_FFFF);
      rd(A_SRST, 32'h0, 32'hFFFF_FFFF);
      print_verdict();
   end

endmodule // test_fsr_regs

`default_nettype wire
